/* hw/mcc_pkg.sv */
/*
  Constants and carrier types for the monitor-mode channel and
  clock control decoder. Assumes a 16-bit instruction parcel split
  into a 7-bit opcode and three 3-bit designators i, j and k.
*/
// Function
// - 0010jk loads word pointer, activates channel
// - 001000 is a pure no-operation
// - 0011jk loads limit address, no activation
// - 0012j0 clears flags, drops output master clear
// - 0012j1 clears flags, sets clear, drops held
// - 0013j0 loads exchange pointer from bits 13..4
// - Outside monitor mode no-op, holds still apply
// - j zero makes channel ops no-op
// - k zero supplies value one
// - 0013 with j zero clears exchange pointer
// - Hold while first operand reserved, except zero
// - 0010/0011 also hold on second operand
// - Channel ops hold on conflict or full buffer
// - Newer variant aligns issue to half-rate clock
// - Issue takes one machine cycle once free
// - Pointer counts to limit, equal means done
// - 0014 loads wall timer, group, interval
// - 0014j1 sends cpu irq; 01, 02 variants
// - 001405 acks, 06 allows, 07 blocks tick
// - 0016j1 sends remote flush request
// - 32-bit tick counts down, fires, reloads
// - Wall timer load with j zero gives zero
package mcc_pkg;
  // Instruction parcel fields
  localparam int         OPC_LSB   = 9;
  localparam int         FI_LSB    = 6;
  localparam int         FJ_LSB    = 3;
  localparam int         FK_LSB    = 0;
  localparam logic [6:0] OPC_MON   = 7'h01;
  localparam logic [2:0] FI_PTR    = 3'h0;
  localparam logic [2:0] FI_LIM    = 3'h1;
  localparam logic [2:0] FI_FLG    = 3'h2;
  localparam logic [2:0] FI_XPT    = 3'h3;
  localparam logic [2:0] FI_CLK    = 3'h4;
  localparam logic [2:0] FI_FLS    = 3'h6;
  localparam logic [2:0] FK_WALL   = 3'h0;
  localparam logic [2:0] FK_IPI    = 3'h1;
  localparam logic [2:0] FK_DROP   = 3'h2;
  localparam logic [2:0] FK_GRP    = 3'h3;
  localparam logic [2:0] FK_INTV   = 3'h4;
  localparam logic [2:0] FK_ACK    = 3'h5;
  localparam logic [2:0] FK_ALLOW  = 3'h6;
  localparam logic [2:0] FK_BLOCK  = 3'h7;
  localparam logic [2:0] FK_FLS    = 3'h1;
  // Widths and positions
  localparam int XP_HI   = 13;
  localparam int XP_LO   = 4;
  localparam int XP_W    = 10;
  localparam int CPU_W   = 8;
  localparam int CHN_W   = 8;
  localparam int TICK_W  = 32;
  localparam int WALL_W  = 64;
  localparam int CH_BASE = 16;
  // Register map
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TICK = 8'h08;
  localparam logic [7:0] REG_CSEL = 8'h0C;
  localparam logic [7:0] REG_CPTR = 8'h10;
  localparam logic [7:0] REG_CLIM = 8'h14;
  localparam logic [7:0] REG_CFLG = 8'h18;
  localparam int CTRL_ALIGN = 0;
  localparam int STAT_TIRQ  = 0;
  localparam int STAT_TEN   = 1;
  localparam int STAT_IPI   = 2;
  localparam int STAT_GRP   = 8;
  localparam int STAT_XP    = 16;
  localparam int CFLG_ACT   = 0;
  localparam int CFLG_IRQ   = 1;
  localparam int CFLG_ERR   = 2;
  localparam int CFLG_MCLR  = 3;
  localparam int CFLG_HELD  = 4;
  // Reset values
  localparam logic             CTRL_ALIGN_RST = 1'b0;
  localparam logic             TICK_EN_RST    = 1'b0;
  localparam logic [CHN_W-1:0] CSEL_RST       = 8'h00;
  localparam logic [1:0]       RESP_OKAY      = 2'h0;
  localparam logic [1:0]       RESP_SLVERR    = 2'h2;
  // Carriers
  typedef struct packed {
    logic             word;
    logic             err;
    logic             held;
    logic [CHN_W-1:0] chan;
  } ch_evt_type;
  typedef struct packed {
    logic             valid;
    logic [CPU_W-1:0] cpu;
  } cpu_req_type;
endpackage : mcc_pkg

/* hw/monitor_channel_control_ops.sv */
/*
  Monitor-mode channel and clock control decoder with an AXI4-Lite
  register slave. Assumes issue-side inputs and channel events come
  from logic on I_CLK, and that the pipeline stalls while O_HOLD.
*/
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module monitor_channel_control_ops
  import mcc_pkg::*;
#(
  parameter int NCH   = 64,
  parameter int A_W   = 32,
  parameter int GRP_W = 6
)(
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_SYS_RST,
  // Issue pipeline
  input  wire logic              I_ISSUE_VALID,
  input  wire logic [15:0]       I_INSN,
  input  wire logic              I_MONITOR,
  input  wire logic [A_W-1:0]    I_AJ_VAL,
  input  wire logic [A_W-1:0]    I_AK_VAL,
  input  wire logic [WALL_W-1:0] I_SJ_VAL,
  input  wire logic              I_AJ_RSV,
  input  wire logic              I_AK_RSV,
  input  wire logic              I_SJ_RSV,
  input  wire logic              I_SHR_CONFLICT,
  input  wire logic              I_BUF_FULL,
  input  wire logic [CPU_W-1:0]  I_CPU_ID,
  output logic                   O_HOLD,
  output logic                   O_ISSUED,
  // Channels
  input  wire ch_evt_type        I_CH_EVT,
  output logic [NCH-1:0]         O_CH_ACTIVE,
  output logic [NCH-1:0]         O_CH_IRQ,
  output logic [NCH-1:0]         O_CH_ERR,
  output logic [NCH-1:0]         O_CH_MCLR,
  output logic [NCH-1:0]         O_CH_HELD,
  // Clocks, interrupts, remote requests
  input  wire logic              I_IPI_IN,
  output cpu_req_type            O_IPI_REQ,
  output cpu_req_type            O_FLUSH_REQ,
  output logic                   O_IPI_PENDING,
  output logic                   O_TICK_IRQ,
  output logic [WALL_W-1:0]      O_WALL_TIMER,
  output logic [XP_W-1:0]        O_EXCH_PTR,
  output logic [GRP_W-1:0]       O_GROUP_NUM,
  // AXI4-Lite slave
  input  wire logic              I_AXI_AWVALID,
  output logic                   O_AXI_AWREADY,
  input  wire logic [ADDR_W-1:0] I_AXI_AWADDR,
  input  wire logic              I_AXI_WVALID,
  output logic                   O_AXI_WREADY,
  input  wire logic [31:0]       I_AXI_WDATA,
  input  wire logic [3:0]        I_AXI_WSTRB,
  output logic                   O_AXI_BVALID,
  input  wire logic              I_AXI_BREADY,
  output logic [1:0]             O_AXI_BRESP,
  input  wire logic              I_AXI_ARVALID,
  output logic                   O_AXI_ARREADY,
  input  wire logic [ADDR_W-1:0] I_AXI_ARADDR,
  output logic                   O_AXI_RVALID,
  input  wire logic              I_AXI_RREADY,
  output logic [31:0]            O_AXI_RDATA,
  output logic [1:0]             O_AXI_RRESP
);
  localparam int CI_W = $clog2(NCH);

  logic [6:0]       opc;
  logic [2:0]       fi;
  logic [2:0]       fj;
  logic [2:0]       fk;
  logic             jz;
  logic             is_ch;
  logic             is_chk;
  logic             is_xp;
  logic             is_ck;
  logic             is_fl;
  logic             mine;
  logic             aj_use;
  logic             sj_use;
  logic             shr_use;
  logic             hold;
  logic             exec;
  logic             in_rng;
  logic [CI_W-1:0]  idx;
  logic [A_W-1:0]   kval;
  logic             ptr_wr;
  logic             lim_wr;
  logic             flg_wr;
  logic             ck_go;
  logic [CPU_W-1:0] tgt;
  logic             tick_load;
  logic             tick_fire;
  logic             ev_rng;
  logic [CI_W-1:0]  eidx;
  logic             ev_hit;
  logic             ev_last;
  logic             phase;
  logic             ctrl_align;
  logic             tick_allow;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] interval;
  logic [CHN_W-1:0] csel;
  logic [A_W-1:0]   wptr [NCH];
  logic [A_W-1:0]   wlim [NCH];

  // Decode
  assign opc    = I_INSN[OPC_LSB +: 7];
  assign fi     = I_INSN[FI_LSB +: 3];
  assign fj     = I_INSN[FJ_LSB +: 3];
  assign fk     = I_INSN[FK_LSB +: 3];
  assign jz     = (fj == 3'h0);
  assign is_ch  = (opc == OPC_MON) && (fi <= FI_FLG);
  assign is_chk = (opc == OPC_MON) && (fi <= FI_LIM);
  assign is_xp  = (opc == OPC_MON) && (fi == FI_XPT);
  assign is_ck  = (opc == OPC_MON) && (fi == FI_CLK);
  assign is_fl  = (opc == OPC_MON) && (fi == FI_FLS) && (fk == FK_FLS);
  assign mine   = I_ISSUE_VALID && (is_ch || is_xp || is_ck || is_fl);

  // Operand use per instruction
  assign aj_use  = is_ch || is_xp || is_fl ||
                   (is_ck && (fk == FK_WALL || fk == FK_IPI ||
                              fk == FK_GRP || fk == FK_INTV));
  assign sj_use  = is_ck && (fk == FK_WALL || fk == FK_IPI ||
                             fk == FK_INTV);
  assign shr_use = is_ch || is_fl ||
                   (is_ck && (fk == FK_WALL || fk == FK_IPI ||
                              fk == FK_GRP));

  // Hold terms stay live outside monitor mode too
  assign hold = mine &&
    ((aj_use && !jz && I_AJ_RSV) ||
     (is_chk && fk != 3'h0 && I_AK_RSV) ||
     (sj_use && !jz && I_SJ_RSV) ||
     (shr_use && (I_SHR_CONFLICT || I_BUF_FULL)) ||
     (shr_use && ctrl_align && !phase));
  assign O_HOLD   = hold;
  assign O_ISSUED = mine && !hold;
  assign exec     = O_ISSUED && I_MONITOR;

  // Channel select; out-of-range numbers do nothing
  assign in_rng = (I_AJ_VAL >= A_W'(CH_BASE)) &&
                  (I_AJ_VAL < A_W'(CH_BASE + NCH));
  assign idx    = CI_W'(I_AJ_VAL - A_W'(CH_BASE));
  assign kval   = (fk == 3'h0) ? A_W'(1) : I_AK_VAL;
  assign ptr_wr = exec && is_ch && !jz && in_rng &&
                  fi == FI_PTR;
  assign lim_wr = exec && is_ch && !jz && in_rng && fi == FI_LIM;
  assign flg_wr = exec && is_ch && !jz && in_rng && fi == FI_FLG;
  assign ck_go  = exec && is_ck;

  // Transfer progress from the shared chip
  assign ev_rng  = (I_CH_EVT.chan >= CHN_W'(CH_BASE)) &&
                   (I_CH_EVT.chan < CHN_W'(CH_BASE + NCH));
  assign eidx    = CI_W'(I_CH_EVT.chan - CHN_W'(CH_BASE));
  assign ev_hit  = I_CH_EVT.word && ev_rng && O_CH_ACTIVE[eidx] &&
                   wptr[eidx] != wlim[eidx];
  assign ev_last = ev_hit &&
                   (wptr[eidx] + A_W'(1) == wlim[eidx]);

  always_ff @(posedge I_CLK)
  begin
    if (ev_hit)
      wptr[eidx] <= wptr[eidx] + A_W'(1);
    if (ptr_wr)
      wptr[idx] <= kval;
    if (lim_wr)
      wlim[idx] <= kval;
  end

  // Per-channel flags; hardware set beats instruction clear
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic sel;
    logic evc;
    assign sel = flg_wr && idx == CI_W'(c);
    assign evc = ev_rng && eidx == CI_W'(c);
    always_ff @(posedge I_CLK)
    begin
      if (I_SYS_RST)
      begin
        O_CH_ACTIVE[c] <= 1'b0;
        O_CH_IRQ[c]    <= 1'b0;
        O_CH_ERR[c]    <= 1'b0;
        O_CH_HELD[c]   <= 1'b0;
      end
      else
      begin
        if (ptr_wr && idx == CI_W'(c))
          O_CH_ACTIVE[c] <= 1'b1;
        else if (evc && ev_last)
          O_CH_ACTIVE[c] <= 1'b0;
        if (evc && ev_last)
          O_CH_IRQ[c] <= 1'b1;
        else if (sel)
          O_CH_IRQ[c] <= 1'b0;
        if (evc && I_CH_EVT.err)
          O_CH_ERR[c] <= 1'b1;
        else if (sel)
          O_CH_ERR[c] <= 1'b0;
        if (evc && I_CH_EVT.held && (CH_BASE + c) % 2 == 0)
          O_CH_HELD[c] <= 1'b1;
        else if (sel && fk[0] && (CH_BASE + c) % 2 == 0)
          O_CH_HELD[c] <= 1'b0;
      end
    end
    // Odd channel numbers are outputs and own a master clear
    always_ff @(posedge I_CLK)
    begin
      if (I_SYS_RST)
        O_CH_MCLR[c] <= 1'b0;
      else if (sel && (CH_BASE + c) % 2 == 1)
        O_CH_MCLR[c] <= fk[0];
    end
  end

  // Exchange pointer
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_EXCH_PTR <= '0;
    else if (exec && is_xp)
      O_EXCH_PTR <= jz ? XP_W'(0) :
                    I_AJ_VAL[XP_HI:XP_LO];
  end

  // Half-rate system clock phase
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      phase <= 1'b0;
    else
      phase <= !phase;
  end

  // Wall timer runs freely between loads
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_WALL_TIMER <= '0;
    else if (ck_go && fk == FK_WALL)
      O_WALL_TIMER <= jz ? WALL_W'(0) : I_SJ_VAL;
    else
      O_WALL_TIMER <= O_WALL_TIMER + WALL_W'(1);
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_GROUP_NUM <= '0;
    else if (ck_go && fk == FK_GRP)
      O_GROUP_NUM <= jz ? GRP_W'(0) :
                     I_AJ_VAL[GRP_W-1:0];
  end

  // Remote requests; a CPU naming itself is ignored
  // j zero names register zero, whose value is 0: CPU 0
  assign tgt = jz ? CPU_W'(0) : I_AJ_VAL[CPU_W-1:0];
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_IPI_REQ   <= '0;
      O_FLUSH_REQ <= '0;
    end
    else
    begin
      O_IPI_REQ.valid   <= ck_go && fk == FK_IPI &&
                           tgt != I_CPU_ID;
      O_IPI_REQ.cpu     <= tgt;
      O_FLUSH_REQ.valid <= exec && is_fl &&
                           tgt != I_CPU_ID;
      O_FLUSH_REQ.cpu   <= tgt;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_IPI_PENDING <= 1'b0;
    else if (I_IPI_IN)
      O_IPI_PENDING <= 1'b1;
    else if (ck_go && jz && fk == FK_DROP)
      O_IPI_PENDING <= 1'b0;
  end

  // Tick counter
  assign tick_load = ck_go && fk == FK_INTV;
  assign tick_fire = !tick_load && tick_cnt == '0;
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      tick_cnt <= '0;
      interval <= '0;
    end
    else if (tick_load)
    begin
      tick_cnt <= jz ? TICK_W'(0) :
                  I_SJ_VAL[TICK_W-1:0];
      interval <= jz ? TICK_W'(0) : I_SJ_VAL[TICK_W-1:0];
    end
    else if (tick_fire)
      tick_cnt <= interval;
    else
      tick_cnt <= tick_cnt - TICK_W'(1);
  end

  // Blocking only masks new requests, a pending one stays
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      tick_allow <= TICK_EN_RST;
    else if (ck_go && jz && fk == FK_ALLOW)
      tick_allow <= 1'b1;
    else if (ck_go && jz && fk == FK_BLOCK)
      tick_allow <= 1'b0;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_TICK_IRQ <= 1'b0;
    else if (tick_fire && tick_allow)
      O_TICK_IRQ <= 1'b1;
    else if (ck_go && jz && fk == FK_ACK)
      O_TICK_IRQ <= 1'b0;
  end

  // AXI4-Lite write side
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_hit;

  assign O_AXI_AWREADY = !aw_have && !O_AXI_BVALID;
  assign O_AXI_WREADY  = !w_have && !O_AXI_BVALID;
  assign wr_hit = aw_addr == REG_CTRL || aw_addr == REG_CSEL;

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      O_AXI_BVALID <= 1'b0;
      O_AXI_BRESP  <= RESP_OKAY;
    end
    else
    begin
      if (I_AXI_AWVALID && O_AXI_AWREADY)
      begin
        aw_have <= 1'b1;
        aw_addr <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY)
      begin
        w_have <= 1'b1;
        w_data <= I_AXI_WDATA;
        w_strb <= I_AXI_WSTRB;
      end
      if (aw_have && w_have)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        O_AXI_BVALID <= 1'b1;
        O_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (O_AXI_BVALID && I_AXI_BREADY)
        O_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      ctrl_align <= CTRL_ALIGN_RST;
      csel       <= CSEL_RST;
    end
    else if (aw_have && w_have && w_strb[0])
    begin
      if (aw_addr == REG_CTRL)
        ctrl_align <= w_data[CTRL_ALIGN];
      if (aw_addr == REG_CSEL)
        csel <= w_data[CHN_W-1:0];
    end
  end

  // AXI4-Lite read side; csel is a raw channel number
  logic            cs_ok;
  logic [CI_W-1:0] cs_i;
  logic [31:0]     rd;
  logic            rd_hit;

  assign cs_ok = (csel >= CHN_W'(CH_BASE)) &&
                 (csel < CHN_W'(CH_BASE + NCH));
  assign cs_i  = CI_W'(csel - CHN_W'(CH_BASE));
  assign O_AXI_ARREADY = !O_AXI_RVALID;

  always_comb
  begin
    rd     = '0;
    rd_hit = 1'b1;
    case (I_AXI_ARADDR)
      REG_CTRL: rd[CTRL_ALIGN] = ctrl_align;
      REG_STAT:
      begin
        rd[STAT_TIRQ] = O_TICK_IRQ;
        rd[STAT_TEN]  = tick_allow;
        rd[STAT_IPI]  = O_IPI_PENDING;
        rd[STAT_GRP +: GRP_W] = O_GROUP_NUM;
        rd[STAT_XP +: XP_W]   = O_EXCH_PTR;
      end
      REG_TICK: rd = tick_cnt;
      REG_CSEL: rd[CHN_W-1:0] = csel;
      REG_CPTR: rd = cs_ok ? 32'(wptr[cs_i]) : 32'h0;
      REG_CLIM: rd = cs_ok ? 32'(wlim[cs_i]) : 32'h0;
      REG_CFLG:
      if (cs_ok)
      begin
        rd[CFLG_ACT]  = O_CH_ACTIVE[cs_i];
        rd[CFLG_IRQ]  = O_CH_IRQ[cs_i];
        rd[CFLG_ERR]  = O_CH_ERR[cs_i];
        rd[CFLG_MCLR] = O_CH_MCLR[cs_i];
        rd[CFLG_HELD] = O_CH_HELD[cs_i];
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_AXI_RVALID <= 1'b0;
      O_AXI_RDATA  <= '0;
      O_AXI_RRESP  <= RESP_OKAY;
    end
    else if (I_AXI_ARVALID && O_AXI_ARREADY)
    begin
      O_AXI_RVALID <= 1'b1;
      O_AXI_RDATA  <= rd;
      O_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (I_AXI_RREADY)
      O_AXI_RVALID <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  a_ptr_activate:
    assert property (ptr_wr |=> O_CH_ACTIVE[$past(idx)] &&
                     wptr[$past(idx)] == $past(kval))
    else $error("pointer write did not load and activate");
  a_pass_code:
    assert property (I_ISSUE_VALID && I_INSN == 16'h0200 |=>
                     $stable(O_EXCH_PTR) && !O_IPI_REQ.valid)
    else $error("pass code changed state");
  a_lim_quiet:
    assert property (lim_wr && !O_CH_ACTIVE[idx] |=>
                     !O_CH_ACTIVE[$past(idx)] &&
                     wlim[$past(idx)] == $past(kval))
    else $error("limit write activated or missed");
  a_mclr_follow:
    assert property (flg_wr && idx[0] == 1'b1 && !I_CH_EVT.word |=>
                     O_CH_MCLR[$past(idx)] == $past(fk[0]) &&
                     !O_CH_IRQ[$past(idx)])
    else $error("flag clear or master clear wrong");
  a_xp_load:
    assert property (exec && is_xp |=> O_EXCH_PTR ==
                     $past(jz ? XP_W'(0) : I_AJ_VAL[XP_HI:XP_LO]))
    else $error("exchange pointer load wrong");
  a_user_pass:
    assert property (O_ISSUED && !I_MONITOR |=> $stable(O_EXCH_PTR)
                     && $stable(O_GROUP_NUM) && !O_FLUSH_REQ.valid)
    else $error("user mode instruction had effect");
  a_j_zero:
    assert property (O_ISSUED && is_ch && jz |=> $stable(O_CH_MCLR))
    else $error("j zero touched a channel");
  a_aj_hold:
    assert property (mine && aj_use && !jz && I_AJ_RSV |-> O_HOLD)
    else $error("issued with first operand reserved");
  a_ak_hold:
    assert property (mine && is_chk && fk != 3'h0 && I_AK_RSV
                     |-> !O_ISSUED)
    else $error("issued with second operand reserved");
  a_shr_hold:
    assert property (mine && is_ch && (I_SHR_CONFLICT || I_BUF_FULL)
                     |-> O_HOLD)
    else $error("issued during shared conflict");
  a_align_phase:
    assert property (O_ISSUED && shr_use && ctrl_align |-> phase)
    else $error("issued off the half-rate phase");
  a_issue_free:
    assert property (mine && !is_fl && !I_AJ_RSV && !I_AK_RSV &&
                     !I_SJ_RSV && !I_SHR_CONFLICT && !I_BUF_FULL &&
                     !ctrl_align |-> O_ISSUED)
    else $error("free instruction did not issue");
  a_xfer_done:
    assert property (ev_last && !ptr_wr |=> !O_CH_ACTIVE[$past(eidx)]
                     && O_CH_IRQ[$past(eidx)])
    else $error("transfer end not flagged");
  a_wall_load:
    assert property (ck_go && fk == FK_WALL |=> O_WALL_TIMER ==
                     $past(jz ? WALL_W'(0) : I_SJ_VAL))
    else $error("wall timer load wrong");
  a_ipi_send:
    assert property (ck_go && fk == FK_IPI && tgt != I_CPU_ID |=>
                     O_IPI_REQ.valid ##1 !O_IPI_REQ.valid || $past(ck_go))
    else $error("cpu irq request not sent");
  a_tick_ack:
    assert property (ck_go && jz && fk == FK_ACK &&
                     !(tick_fire && tick_allow) |=> !O_TICK_IRQ)
    else $error("tick ack did not clear");
  a_flush_send:
    assert property (exec && is_fl && tgt != I_CPU_ID |=>
                     O_FLUSH_REQ.valid && O_FLUSH_REQ.cpu == $past(tgt))
    else $error("flush request not sent");
  a_tick_reload:
    assert property (tick_fire |=> tick_cnt == $past(interval))
    else $error("tick counter did not reload");

  c_ptr_write: cover property (ptr_wr);
  c_xfer_done: cover property (ev_last);
  c_tick_irq:  cover property (tick_fire && tick_allow);
  c_held:      cover property (O_HOLD ##1 O_ISSUED);
endmodule : monitor_channel_control_ops
`default_nettype wire

/* test/chan_feed.sv */
/* Shared-chip stand-in: word events for one channel while active.
   Assumes the decoder's clock and synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module chan_feed
  import mcc_pkg::*;
#(
  parameter int CH = 1
)(
  // Clock, reset, channel state
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [63:0] i_act,
  // Events
  output var ch_evt_type   o_evt
);
  // Idle chan flips, so a stale number is out of range every other cycle
  always_ff @(posedge i_clk)
  begin
    o_evt <= {3'b000, ~o_evt.chan};
    if (i_rst)
      o_evt <= '0;
    else if (i_act[CH] && !o_evt.word)
      o_evt <= {3'b100, 8'(CH_BASE + CH)};
  end
endmodule : chan_feed
`default_nettype wire

/* test/monitor_channel_control_ops_tb_top.sv */
/* Issue and AXI tasks with checks. Assumes chan_feed on events. */
`timescale 1ns/1ps
`default_nettype none
module monitor_channel_control_ops_tb_top;
  import mcc_pkg::*;
  logic I_CLK, I_SYS_RST, I_ISSUE_VALID, I_MONITOR, I_AJ_RSV, I_AK_RSV;
  logic I_SJ_RSV, I_SHR_CONFLICT, I_BUF_FULL, I_IPI_IN, I_AXI_AWVALID;
  logic I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY;
  logic O_HOLD, O_ISSUED, O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID;
  logic O_AXI_ARREADY, O_AXI_RVALID, O_IPI_PENDING, O_TICK_IRQ;
  logic [15:0] I_INSN;
  logic [31:0] I_AJ_VAL, I_AK_VAL, I_AXI_WDATA, O_AXI_RDATA, rd;
  logic [63:0] I_SJ_VAL, O_CH_ACTIVE, O_CH_IRQ, O_CH_ERR, O_CH_MCLR;
  logic [63:0] O_CH_HELD, O_WALL_TIMER;
  logic [7:0]  I_CPU_ID, I_AXI_AWADDR, I_AXI_ARADDR;
  logic [3:0]  I_AXI_WSTRB;
  logic [9:0]  O_EXCH_PTR;
  logic [5:0]  O_GROUP_NUM;
  logic [1:0]  O_AXI_BRESP, O_AXI_RRESP, rr;
  ch_evt_type  I_CH_EVT;
  cpu_req_type O_IPI_REQ, O_FLUSH_REQ;
  int err_count = 0;
  int checked = 0;
  int n;
  monitor_channel_control_ops i_monitor_channel_control_ops (.*);
  chan_feed i_chan_feed (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_act(O_CH_ACTIVE), .o_evt(I_CH_EVT));
  initial
  begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  task automatic close_out;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic quit;
    err_count++;
    close_out();
  endtask : quit
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e)
      $display("ERROR %s exp %h got %h", nm, e, s);
    if (s !== e)
      err_count++;
  endtask : chk
  // Held until taken; effects checked one edge later
  task automatic iss(input logic [8:0] ijk, input logic [31:0] aj, ak);
    I_ISSUE_VALID <= 1'b1;
    I_INSN <= {OPC_MON, ijk};
    I_AJ_VAL <= aj;
    I_AK_VAL <= ak;
    for (n = 0; n < 20 && O_ISSUED !== 1'b1; n++) @(posedge I_CLK);
    I_ISSUE_VALID <= 1'b0;
    if (n == 20) quit();
    @(posedge I_CLK);
  endtask : iss
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    {I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY} <= 3'b111;
    I_AXI_AWADDR <= a;
    I_AXI_WDATA <= d;
    for (n = 0; n < 20 && O_AXI_BVALID !== 1'b1; n++)
    begin
      @(posedge I_CLK);
      if (O_AXI_AWREADY === 1'b1) I_AXI_AWVALID <= 1'b0;
      if (O_AXI_WREADY === 1'b1) I_AXI_WVALID <= 1'b0;
    end
    I_AXI_BREADY <= 1'b0;
    if (n == 20) quit();
    chk("bresp", O_AXI_BRESP, RESP_OKAY);
    @(posedge I_CLK);
  endtask : axw
  task automatic axr(input logic [7:0] a);
    {I_AXI_ARVALID, I_AXI_RREADY} <= 2'b11;
    I_AXI_ARADDR <= a;
    for (n = 0; n < 20 && O_AXI_RVALID !== 1'b1; n++)
    begin
      @(posedge I_CLK);
      if (O_AXI_ARREADY === 1'b1) I_AXI_ARVALID <= 1'b0;
    end
    {rd, rr} = {O_AXI_RDATA, O_AXI_RRESP};
    I_AXI_RREADY <= 1'b0;
    if (n == 20) quit();
    @(posedge I_CLK);
  endtask : axr
  initial
  begin
    {I_ISSUE_VALID, I_AJ_RSV, I_AK_RSV, I_SJ_RSV, I_SHR_CONFLICT} = '0;
    {I_BUF_FULL, I_IPI_IN, I_AXI_AWVALID, I_AXI_WVALID} = '0;
    {I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY, I_INSN, I_AJ_VAL} = '0;
    {I_AK_VAL, I_SJ_VAL, I_CPU_ID, I_AXI_AWADDR, I_AXI_ARADDR} = '0;
    {I_AXI_WDATA, I_AXI_WSTRB, I_MONITOR, I_SYS_RST} = {36'hF, 2'b11};
    repeat (6) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    // Limit first: the pointer write starts the transfer
    iss(9'o113, 32'h11, 32'h3);
    iss(9'o010, 32'h11, 32'h0);
    chk("act", O_CH_ACTIVE[1], 1'b1);
    for (n = 0; n < 20 && O_CH_IRQ[1] !== 1'b1; n++) @(posedge I_CLK);
    chk("done", {O_CH_ACTIVE[1], O_CH_IRQ[1]}, 2'b01);
    axw(REG_CSEL, 32'h11);
    axr(REG_CPTR);
    chk("ptr", rd, 32'h3);
    axr(REG_CLIM);
    chk("lim", rd, 32'h3);
    iss(9'o211, 32'h11, 32'h0);
    chk("mc", {O_CH_IRQ[1], O_CH_MCLR[1]}, 2'b01);
    iss(9'o210, 32'h11, 32'h0);
    chk("ci", O_CH_MCLR[1], 1'b0);
    iss(9'o310, 32'h3FF0, 32'h0);
    chk("xp", O_EXCH_PTR, 10'h3FF);
    I_SJ_VAL <= 64'h123;
    iss(9'o410, 32'h0, 32'h0);
    chk("wall", O_WALL_TIMER[31:0], 32'h123);
    iss(9'o400, 32'h0, 32'h0);
    chk("wall0", O_WALL_TIMER[31:0], 32'h0);
    I_SJ_VAL <= 64'h40;
    iss(9'o414, 32'h0, 32'h0);
    iss(9'o406, 32'h0, 32'h0);
    for (n = 0; n < 100 && O_TICK_IRQ !== 1'b1; n++) @(posedge I_CLK);
    chk("tick", O_TICK_IRQ, 1'b1);
    iss(9'o405, 32'h0, 32'h0);
    chk("tack", O_TICK_IRQ, 1'b0);
    iss(9'o413, 32'h2A, 32'h0);
    chk("grp", O_GROUP_NUM, 6'h2A);
    iss(9'o411, 32'h5, 32'h0);
    chk("sip", O_IPI_REQ, 9'h105);
    I_IPI_IN <= 1'b1;
    @(posedge I_CLK);
    I_IPI_IN <= 1'b0;
    @(posedge I_CLK);
    chk("ipip", O_IPI_PENDING, 1'b1);
    iss(9'o402, 32'h0, 32'h0);
    chk("ipic", O_IPI_PENDING, 1'b0);
    iss(9'o611, 32'h7, 32'h0);
    chk("ivc", O_FLUSH_REQ, 9'h107);
    I_MONITOR <= 1'b0;
    iss(9'o310, 32'h10, 32'h0);
    chk("pass", O_EXCH_PTR, 10'h3FF);
    {I_MONITOR, I_AJ_RSV} <= 2'b11;
    iss(9'o300, 32'h0, 32'h0);
    chk("xp0", O_EXCH_PTR, 10'h000);
    {I_ISSUE_VALID, I_INSN} <= {1'b1, OPC_MON, 9'o310};
    repeat (2) @(posedge I_CLK);
    chk("hold", O_HOLD, 1'b1);
    {I_ISSUE_VALID, I_AJ_RSV, I_BUF_FULL} <= 3'b001;
    @(posedge I_CLK);
    {I_ISSUE_VALID, I_INSN[8:0]} <= {1'b1, 9'o210};
    repeat (2) @(posedge I_CLK);
    chk("full", O_HOLD, 1'b1);
    {I_ISSUE_VALID, I_BUF_FULL} <= 2'b00;
    // Half-rate alignment on: issue may wait one cycle
    axw(REG_CTRL, 32'h1);
    iss(9'o112, 32'h12, 32'h7);
    axw(REG_CSEL, 32'h12);
    axr(REG_CLIM);
    chk("align", rd, 32'h7);
    axr(8'hFC);
    chk("resp", rr, RESP_SLVERR);
    close_out();
  end
endmodule : monitor_channel_control_ops_tb_top
`default_nettype wire
